// >>> rtl/dcr_pkg.sv
// Constants and carrier types for the DMA channel register interface
package dcr_pkg;
    localparam int          NUM_CHAN      = 4;
    localparam logic [2:0]  FN_STATUS_CMD = 3'h0;
    localparam logic [2:0]  FN_REQUEST    = 3'h1;
    localparam logic [2:0]  FN_SINGLE_MSK = 3'h2;
    localparam logic [2:0]  FN_MODE       = 3'h3;
    localparam logic [2:0]  FN_CLR_BYTE   = 3'h4;
    localparam logic [2:0]  FN_TEMP_CLR   = 3'h5;
    localparam logic [2:0]  FN_ALL_MSK    = 3'h7;
    localparam logic [7:0]  CMD_RESET     = 8'h00;
    localparam logic [3:0]  MASK_RESET    = 4'hF;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [7:0]  ILLEGAL_READ  = 8'h00;
    localparam int          MODE_DEC_BIT  = 3;
    localparam int          MODE_AUTO_BIT = 2;

    typedef struct packed {
        logic [15:0] base_addr;
        logic [15:0] cur_addr;
        logic [15:0] base_cnt;
        logic [15:0] cur_cnt;
    } dcr_chan_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
    } dcr_xfer_t;
endpackage

// >>> rtl/dcr_top.sv
// Register file and per-channel address and count state of a four-channel DMA controller
module dcr_top (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        chip_select_n,
    input  wire logic        host_read_strobe_n,
    input  wire logic        host_write_strobe_n,
    input  wire logic [3:0]  register_select_lines,
    input  wire logic [7:0]  host_data_lines_in,
    output logic      [7:0]  host_data_lines_out,
    output logic             host_data_lines_oe_n,
    input  wire logic [3:0]  channel_request_in,
    input  wire logic        transfer_done_signal_in_n,
    output logic             transfer_done_signal_out_n,
    output logic             transfer_done_signal_oe_n,
    input  wire logic        xfer_word_done,
    input  wire logic [1:0]  xfer_chan,
    input  wire logic        xfer_active,
    input  wire logic [7:0]  temp_byte_in,
    output logic      [7:0]  global_control_word_q,
    output logic      [3:0]  soft_trigger_bits_q,
    output logic      [3:0]  channel_block_bits_q,
    output logic      [23:0] channel_transfer_setup_q,
    output logic      [15:0] active_addr_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: strobes, select, select lines, requests, external end

    logic [8:0] pin_s1_q;
    logic [8:0] pin_s2_q;
    logic [3:0] req_s1_q;
    logic [3:0] req_s2_q;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_q <= 9'h1FF;
            pin_s2_q <= 9'h1FF;
            req_s1_q <= 4'h0;
            req_s2_q <= 4'h0;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= {transfer_done_signal_in_n, chip_select_n, host_read_strobe_n,
                         host_write_strobe_n, register_select_lines, 1'b1};
            pin_s2_q <= pin_s1_q;
            req_s1_q <= channel_request_in;
            req_s2_q <= req_s1_q;
            din_s1_q <= host_data_lines_in;
            din_s2_q <= din_s1_q;
        end
    end

    logic       ext_done;
    logic       cs_ok;
    logic       rd_lvl;
    logic       wr_lvl;
    logic [3:0] sel;
    logic       rd_prev_q;
    logic       wr_prev_q;
    logic       rd_pulse;
    logic       wr_pulse;

    assign ext_done = ~pin_s2_q[8];
    assign sel      = pin_s2_q[4:1];
    // Strobes honoured only while selected and no transfer owns the bus
    assign cs_ok    = ~pin_s2_q[7] & ~xfer_active;
    assign rd_lvl   = ~pin_s2_q[6] & cs_ok & pin_s2_q[5];
    assign wr_lvl   = ~pin_s2_q[5] & cs_ok & pin_s2_q[6];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_lvl;
            wr_prev_q <= wr_lvl;
        end
    end

    // One access per strobe; the trailing edge of a read closes it so that
    // status clearing follows the data the host actually saw
    // Select and chip select must therefore still stand when the read strobe rises
    assign rd_pulse = rd_prev_q & ~rd_lvl & ~pin_s2_q[7];
    assign wr_pulse = wr_lvl & ~wr_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic       chan_sel;
    logic [1:0] sel_chan;
    logic [2:0] fn;
    logic       chan_acc;
    logic       chan_wr;
    logic       mclr;
    logic       clr_byte;
    logic       stat_rd;

    assign chan_sel = ~sel[3];
    assign sel_chan = sel[2:1];
    assign fn       = sel[2:0];
    assign chan_acc = chan_sel & (rd_pulse | wr_pulse);
    assign chan_wr  = chan_sel & wr_pulse;
    // Only the documented function codes act; others fall through untouched
    assign mclr     = ~chan_sel & wr_pulse & (fn == dcr_pkg::FN_TEMP_CLR);
    assign clr_byte = ~chan_sel & wr_pulse & (fn == dcr_pkg::FN_CLR_BYTE);
    assign stat_rd  = ~chan_sel & rd_pulse & (fn == dcr_pkg::FN_STATUS_CMD);

    ////////////////////////////////////////////////////////////////////////////
    // Byte select flip-flop

    logic byte_hi_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            byte_hi_q <= 1'b0;
        end else if (mclr || clr_byte) begin
            byte_hi_q <= 1'b0;
        end else if (chan_acc) begin
            byte_hi_q <= ~byte_hi_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [1:0] dsel;
    assign dsel = din_s2_q[1:0];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            global_control_word_q <= dcr_pkg::CMD_RESET;
        end else if (mclr) begin
            global_control_word_q <= dcr_pkg::CMD_RESET;
        end else if (~chan_sel && wr_pulse && fn == dcr_pkg::FN_STATUS_CMD) begin
            global_control_word_q <= din_s2_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel_transfer_setup_q <= 24'h000000;
        end else if (~chan_sel && wr_pulse && fn == dcr_pkg::FN_MODE) begin
            channel_transfer_setup_q[dsel*6 +: 6] <= din_s2_q[7:2];
        end
    end

    logic [3:0] done_evt;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            soft_trigger_bits_q <= 4'h0;
        end else if (mclr) begin
            soft_trigger_bits_q <= 4'h0;
        end else if (~chan_sel && wr_pulse && fn == dcr_pkg::FN_REQUEST) begin
            soft_trigger_bits_q[dsel] <= din_s2_q[2];
        end else begin
            soft_trigger_bits_q <= soft_trigger_bits_q & ~done_evt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel_block_bits_q <= dcr_pkg::MASK_RESET;
        end else if (mclr) begin
            channel_block_bits_q <= dcr_pkg::MASK_RESET;
        end else if (~chan_sel && wr_pulse && fn == dcr_pkg::FN_SINGLE_MSK) begin
            channel_block_bits_q[dsel] <= din_s2_q[2];
        end else if (~chan_sel && wr_pulse && fn == dcr_pkg::FN_ALL_MSK) begin
            channel_block_bits_q <= din_s2_q[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel address and count registers

    dcr_pkg::dcr_chan_t chan_q [dcr_pkg::NUM_CHAN];
    logic [3:0]         zero_hit;
    logic               any_end;

    // Internal end comes from a count wrap; an external end hits the active channel
    assign any_end = ext_done & xfer_active;

    genvar gi;
    generate
        for (gi = 0; gi < dcr_pkg::NUM_CHAN; gi++) begin : g_chan
            localparam logic [1:0] CHAN_ID = 2'(gi);
            logic step;
            logic auto_en;
            logic dec_en;
            assign step     = xfer_word_done & (xfer_chan == CHAN_ID);
            assign auto_en  = channel_transfer_setup_q[gi*6 + dcr_pkg::MODE_AUTO_BIT];
            assign dec_en   = channel_transfer_setup_q[gi*6 + dcr_pkg::MODE_DEC_BIT];
            assign zero_hit[gi] = step & (chan_q[gi].cur_cnt == 16'h0000);
            assign done_evt[gi] = zero_hit[gi] | (any_end & (xfer_chan == CHAN_ID));

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    chan_q[gi] <= '0;
                end else if (chan_wr && sel_chan == CHAN_ID && !sel[0]) begin
                    if (byte_hi_q) begin
                        chan_q[gi].base_addr[15:8] <= din_s2_q;
                        chan_q[gi].cur_addr[15:8]  <= din_s2_q;
                    end else begin
                        chan_q[gi].base_addr[7:0]  <= din_s2_q;
                        chan_q[gi].cur_addr[7:0]   <= din_s2_q;
                    end
                end else if (chan_wr && sel_chan == CHAN_ID && sel[0]) begin
                    if (byte_hi_q) begin
                        chan_q[gi].base_cnt[15:8]  <= din_s2_q;
                        chan_q[gi].cur_cnt[15:8]   <= din_s2_q;
                    end else begin
                        chan_q[gi].base_cnt[7:0]   <= din_s2_q;
                        chan_q[gi].cur_cnt[7:0]    <= din_s2_q;
                    end
                end else if (done_evt[gi] && auto_en) begin
                    chan_q[gi].cur_addr <= chan_q[gi].base_addr;
                    chan_q[gi].cur_cnt  <= chan_q[gi].base_cnt;
                end else if (step) begin
                    chan_q[gi].cur_addr <= dec_en ? chan_q[gi].cur_addr - 16'h0001
                                                  : chan_q[gi].cur_addr + 16'h0001;
                    chan_q[gi].cur_cnt  <= chan_q[gi].cur_cnt - 16'h0001;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Status register and end-of-transfer output

    logic [3:0] done_flags_q;
    logic       done_pulse_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_flags_q <= 4'h0;
        end else begin
            // New ends win over a read clear in the same cycle
            done_flags_q <= ((stat_rd || mclr) ? 4'h0 : done_flags_q) | done_evt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_pulse_q              <= 1'b0;
            transfer_done_signal_out_n <= 1'b1;
            transfer_done_signal_oe_n  <= 1'b1;
            active_addr_q              <= dcr_pkg::REG_RESET;
        end else begin
            // A zero hit right behind another folds into the pulse already out,
            // so the done output never stays low past one clock
            done_pulse_q               <= |zero_hit & ~done_pulse_q;
            transfer_done_signal_out_n <= ~(|zero_hit & ~done_pulse_q);
            transfer_done_signal_oe_n  <= ~(|zero_hit & ~done_pulse_q);
            active_addr_q              <= chan_q[xfer_chan].cur_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [15:0] rd_word;
    logic [7:0]  rd_byte;

    always_comb begin
        rd_word = sel[0] ? chan_q[sel_chan].cur_cnt : chan_q[sel_chan].cur_addr;
        if (chan_sel) begin
            rd_byte = byte_hi_q ? rd_word[15:8] : rd_word[7:0];
        end else if (fn == dcr_pkg::FN_STATUS_CMD) begin
            // High nibble is the live request level, untouched by reads
            rd_byte = {req_s2_q, done_flags_q};
        end else if (fn == dcr_pkg::FN_TEMP_CLR) begin
            rd_byte = temp_byte_in;
        end else begin
            rd_byte = dcr_pkg::ILLEGAL_READ;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            host_data_lines_out  <= 8'h00;
            host_data_lines_oe_n <= 1'b1;
        end else begin
            host_data_lines_out  <= rd_byte;
            host_data_lines_oe_n <= ~rd_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_byte_toggle: assert property (@(posedge core_clk) disable iff (!rstn)
        chan_acc && !mclr && !clr_byte |=> byte_hi_q != $past(byte_hi_q))
        else $error("byte select did not toggle");
    a_byte_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        mclr || clr_byte |=> !byte_hi_q)
        else $error("byte select not cleared");
    a_status_set: assert property (@(posedge core_clk) disable iff (!rstn)
        done_evt[0] |=> done_flags_q[0])
        else $error("status bit not set");
    a_status_clr: assert property (@(posedge core_clk) disable iff (!rstn)
        stat_rd && done_evt == 4'h0 |=> done_flags_q == 4'h0)
        else $error("status not cleared by read");
    a_done_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        !transfer_done_signal_out_n |=> transfer_done_signal_out_n)
        else $error("done pulse too long");
    a_done_fires: assert property (@(posedge core_clk) disable iff (!rstn)
        |zero_hit && !done_pulse_q |=> !transfer_done_signal_out_n)
        else $error("done pulse missing");
    a_count_dec: assert property (@(posedge core_clk) disable iff (!rstn)
        xfer_word_done && xfer_chan == 2'h0 && !chan_wr && !done_evt[0]
        |=> chan_q[0].cur_cnt == $past(chan_q[0].cur_cnt) - 16'h0001)
        else $error("count not decremented");
    a_addr_step: assert property (@(posedge core_clk) disable iff (!rstn)
        xfer_word_done && xfer_chan == 2'h0 && !chan_wr && !done_evt[0]
        && !channel_transfer_setup_q[dcr_pkg::MODE_DEC_BIT]
        |=> chan_q[0].cur_addr == $past(chan_q[0].cur_addr) + 16'h0001)
        else $error("address did not step up");
    a_auto_reload: assert property (@(posedge core_clk) disable iff (!rstn)
        done_evt[1] && channel_transfer_setup_q[6 + dcr_pkg::MODE_AUTO_BIT] && !chan_wr
        |=> chan_q[1].cur_cnt == chan_q[1].base_cnt && chan_q[1].cur_addr == chan_q[1].base_addr)
        else $error("current not reloaded from base");
    // Only the written byte is compared: the other half may differ after transfers
    a_base_load: assert property (@(posedge core_clk) disable iff (!rstn)
        chan_wr && sel_chan == 2'h0 && !sel[0] && !byte_hi_q
        |=> chan_q[0].base_addr[7:0] == $past(din_s2_q) && chan_q[0].cur_addr[7:0] == $past(din_s2_q))
        else $error("base and current not loaded together");
    a_strobe_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        xfer_active |=> $stable(chan_q[0].base_addr) && $stable(global_control_word_q))
        else $error("strobe accepted during transfer");
    a_read_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_lvl |=> !host_data_lines_oe_n)
        else $error("read data not driven");
    a_mask_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        mclr |=> channel_block_bits_q == dcr_pkg::MASK_RESET
                 && global_control_word_q == dcr_pkg::CMD_RESET)
        else $error("master clear incomplete");
    a_illegal_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        !chan_sel && wr_pulse && fn == 3'h6
        |=> $stable(byte_hi_q) && $stable(global_control_word_q)
            && $stable(channel_block_bits_q))
        else $error("illegal write changed state");

endmodule

// >>> verif/dcr_host_model.sv
// Host processor model making programmed byte accesses to the register interface
module dcr_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output logic            chip_select_n,
    output logic            read_n,
    output logic            write_n,
    output logic      [3:0] sel,
    output logic      [7:0] data_in,
    output logic            rd_vld,
    output logic      [7:0] rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        sel = 4'hF;
        data_in = 8'h00;
        rd_vld = 1'b0;
        rd_byte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobes held five clocks; a read keeps select and chip select two clocks past
    // its strobe, since the register side acts on the read's trailing edge
    // Callers also issue illegal select and strobe pairs, such as a read of select 9 and a write of select E
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(posedge core_clk);
        #2;
        chip_select_n = 1'b0;
        sel = s;
        data_in = d;
        write_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #2;
        write_n = 1'b1;
        chip_select_n = 1'b1;
        sel = ~s;
        // Released bus shows the inverse, so stale data cannot pass as fresh
        data_in = ~d;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic rd(input logic [3:0] s);
        @(posedge core_clk);
        #2;
        chip_select_n = 1'b0;
        sel = s;
        read_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #2;
        rd_byte = (data_oe_n === 1'b0) ? data_out : 8'hXX;
        read_n = 1'b1;
        rd_vld = 1'b1;
        @(posedge core_clk);
        #2;
        rd_vld = 1'b0;
        @(posedge core_clk);
        #2;
        chip_select_n = 1'b1;
        sel = ~s;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// >>> verif/tb.sv
// Self-checking testbench for the DMA channel register interface
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, rstn, cs_n, rd_n, wr_n, oe_n, done_out_n, done_oe_n, done_in_n;
    logic        word_done, active, rd_vld;
    logic [1:0]  chan;
    logic [3:0]  sel, req, trig, block;
    logic [7:0]  din, dout, temp, ctrl, rd_byte;
    logic [23:0] setup;
    logic [15:0] vals [8];
    logic [15:0] addr;
    logic [15:0] prog [4];
    logic [7:0]  exp_q [$];
    string       nm_q [$];
    int          num_errors, num_checks, seed, done_cnt, i;

    dcr_top dut_u (.core_clk(core_clk), .rstn(rstn), .chip_select_n(cs_n),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
        .register_select_lines(sel), .host_data_lines_in(din),
        .host_data_lines_out(dout), .host_data_lines_oe_n(oe_n),
        .channel_request_in(req), .transfer_done_signal_in_n(done_in_n),
        .transfer_done_signal_out_n(done_out_n), .transfer_done_signal_oe_n(done_oe_n),
        .xfer_word_done(word_done), .xfer_chan(chan), .xfer_active(active),
        .temp_byte_in(temp), .global_control_word_q(ctrl), .soft_trigger_bits_q(trig),
        .channel_block_bits_q(block), .channel_transfer_setup_q(setup), .active_addr_q(addr));

    dcr_host_model host_u (.core_clk(core_clk), .data_out(dout), .data_oe_n(oe_n),
        .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n), .sel(sel), .data_in(din),
        .rd_vld(rd_vld), .rd_byte(rd_byte));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd_exp(input logic [3:0] s, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        host_u.rd(s);
    endtask

    task automatic word(input logic [1:0] c);
        @(posedge core_clk);
        #2;
        chan = c;
        word_done = 1'b1;
        @(posedge core_clk);
        #2;
        word_done = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Oldest note is matched against each completed host read
    always @(posedge core_clk) begin
        if (rd_vld === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 24'h0, 24'h1);
            else
                chk(nm_q.pop_front(), {16'h0, exp_q.pop_front()}, {16'h0, rd_byte});
        end
        if (done_out_n === 1'b0 && done_oe_n === 1'b0)
            done_cnt++;
    end

    initial begin
        #(25 * 5000);
        num_errors++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 47551;
        rstn = 1'b0;
        done_in_n = 1'b1;
        word_done = 1'b0;
        active = 1'b0;
        chan = 2'h0;
        req = 4'h0;
        temp = 8'h00;
        prog = '{16'h0100, 16'h0005, 16'h0200, 16'h0000};
        repeat (12) @(posedge core_clk);
        #2;
        rstn = 1'b1;
        req = 4'($random(seed));
        temp = 8'($random(seed));
        for (i = 0; i < 8; i++) begin
            vals[i] = 16'($random(seed));
            host_u.wr(4'(i), vals[i][7:0]);
            host_u.wr(4'(i), vals[i][15:8]);
        end
        host_u.wr(4'hC, 8'h00);
        for (i = 0; i < 8; i++) begin
            rd_exp(4'(i), vals[i][7:0], "chan low byte");
            rd_exp(4'(i), vals[i][15:8], "chan high byte");
        end
        // Lone byte, then pointer clear, then illegal accesses inside a pair
        host_u.wr(4'h4, 8'hAA);
        host_u.wr(4'hC, 8'h00);
        host_u.wr(4'h4, 8'h34);
        host_u.wr(4'h4, 8'h12);
        rd_exp(4'h4, 8'h34, "ch2 low after clear");
        rd_exp(4'h9, dcr_pkg::ILLEGAL_READ, "illegal read");
        host_u.wr(4'hE, 8'h55);
        rd_exp(4'h4, 8'h12, "ch2 high after illegal");
        rd_exp(4'hD, temp, "temporary byte");
        #2;
        active = 1'b1;
        host_u.wr(4'h0, 8'hEE);
        #2;
        active = 1'b0;
        rd_exp(4'h0, vals[0][7:0], "refused write");
        host_u.wr(4'h8, 8'hA5);
        chk("control word", 24'h0000A5, {16'h0, ctrl});
        host_u.wr(4'h9, 8'h05);
        chk("soft trigger", 24'h000002, {20'h0, trig});
        host_u.wr(4'hA, 8'h02);
        chk("single block", 24'h00000B, {20'h0, block});
        host_u.wr(4'hF, 8'h0A);
        chk("all block", 24'h00000A, {20'h0, block});
        host_u.wr(4'hB, 8'h00);
        host_u.wr(4'hB, 8'h31);
        chk("transfer setup", 24'h000300, setup);
        // Ch0 counts up plainly; ch1 counts down with reload, starting at zero
        host_u.wr(4'hC, 8'h00);
        for (i = 0; i < 4; i++) begin
            host_u.wr(4'(i), prog[i][7:0]);
            host_u.wr(4'(i), prog[i][15:8]);
        end
        #2;
        active = 1'b1;
        word(2'h0);
        word(2'h0);
        chk("active address", 24'h000102, {8'h0, addr});
        #2;
        done_in_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #2;
        done_in_n = 1'b1;
        // Let the synchronised end fall away before channel 1 steps
        repeat (3) @(posedge core_clk);
        done_cnt = 0;
        word(2'h1);
        repeat (4) @(posedge core_clk);
        chk("done pulse count", 24'h000001, 24'(done_cnt));
        #2;
        active = 1'b0;
        repeat (4) @(posedge core_clk);
        host_u.wr(4'hC, 8'h00);
        rd_exp(4'h0, 8'h02, "ch0 addr low");
        rd_exp(4'h0, 8'h01, "ch0 addr high");
        rd_exp(4'h1, 8'h03, "ch0 count low");
        rd_exp(4'h1, 8'h00, "ch0 count high");
        rd_exp(4'h2, 8'h00, "ch1 addr low");
        rd_exp(4'h2, 8'h02, "ch1 addr high");
        rd_exp(4'h3, 8'h00, "ch1 count low");
        rd_exp(4'h3, 8'h00, "ch1 count high");
        rd_exp(4'h8, {req, 4'h3}, "status set");
        rd_exp(4'h8, {req, 4'h0}, "status cleared");
        host_u.wr(4'h0, 8'h77);
        host_u.wr(4'hD, 8'h00);
        chk("control after clear", 24'h0, {16'h0, ctrl});
        chk("block after clear", 24'h00000F, {20'h0, block});
        host_u.wr(4'h0, 8'h34);
        host_u.wr(4'h0, 8'h12);
        host_u.wr(4'hC, 8'h00);
        rd_exp(4'h0, 8'h34, "low after master clear");
        rd_exp(4'h0, 8'h12, "high after master clear");
        repeat (4) @(posedge core_clk);
        tally_and_finish;
    end
endmodule
